// [core/pfs_defs.vh]
// constants for the pad function select block
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// pad configuration field codes (4-bit mode field per pad)
`define PFS_CFG_ANALOG 4'h0
`define PFS_CFG_OUT 4'h1
`define PFS_CFG_OUT_OD 4'h5
`define PFS_CFG_ALT 4'h9
`define PFS_CFG_ALT_OD 4'hd

// field positions
`define PFS_PA7_CFG_HI 15
`define PFS_PA7_CFG_LO 12
`define PFS_PB3_CFG_HI 15
`define PFS_PB3_CFG_LO 12
`define PFS_PB4_CFG_HI 3
`define PFS_PB4_CFG_LO 0
`define PFS_PA0_CFG_HI 3
`define PFS_PA0_CFG_LO 0
`define PFS_DBG_REGEN_DIS_BIT 4
`define PFS_T2_REMAP_C1_BIT 4
`define PFS_T2_REMAP_C3_BIT 6
`define PFS_T2_REMAP_C4_BIT 7
`define PFS_UART_HS_EN_BIT 5
`define PFS_SPI_SLAVE_BIT 4

// serial controller mode codes
`define PFS_MODE_OFF 2'h0
`define PFS_MODE_UART 2'h1
`define PFS_MODE_SPI 2'h2
`define PFS_MODE_TWI 2'h3

// channel enable bit positions (output enable of channel n at bit 4*(n-1))
`define PFS_CCER_C1_BIT 0
`define PFS_CCER_C3_BIT 8
`define PFS_CCER_C4_BIT 12

`endif

// [core/pfs_pad_function_select.v]
// pad multiplexing for four pads: regulator enable, timers, serial, usb
//
// Contract
// - port a bit7 drives regulator enable after reset
// - debug bit 4 frees bit7 pad
// - timer1 ch4 out needs enable and alt
// - timer1 ch4 input always from bit7 pad
// - remap bit 6 moves timer2 ch3 to PB3-pad
// - remap bit 7 moves timer2 ch4 to PB4-pad
// - remap bit 4 clear keeps ch1 on PA0-pad
// - timer2 outputs drive only when channel enabled
// - port b bit3 alt output needs alt config
// - port b bit4 alt output needs alt config
// - port a bit0 alt output needs alt config
// - usb minus on bit0 pad when analog
// - uart handshake needs enable bit and uart mode
// - serial1 spi role sets clock and select direction
// - bit4 pad feeds slave select in slave
// - serial2 spi role sets bit0 data direction
// - serial function only in matching mode
`timescale 1ns/1ns
`default_nettype none
`include "pfs_defs.vh"

module pfs_pad_function_select #(
    parameter HAS_USB = 1
) (
    input wire sys_clk,
    input wire arst_n,
    // configuration bits
    input wire [15:0] porta_high_config,
    input wire [15:0] porta_low_config,
    input wire [15:0] portb_low_config,
    input wire [15:0] portb_high_config,
    input wire [7:0] debug_pin_config,
    input wire [7:0] timer2_remap_option,
    input wire [15:0] timer1_channel_enable,
    input wire [15:0] timer2_channel_enable,
    input wire [7:0] serial1_uart_config,
    input wire [7:0] serial1_spi_config,
    input wire [1:0] serial1_mode_select,
    input wire [7:0] serial2_spi_config,
    input wire [1:0] serial2_mode_select,
    // general-purpose port output values
    input wire [3:0] gpio_out,
    // peripheral outputs toward pads
    input wire reg_enable_n,
    input wire timer1_channel4_out,
    input wire timer2_channel1_out,
    input wire timer2_channel3_out,
    input wire timer2_channel4_out,
    input wire serial1_spi_clock_out,
    input wire serial1_request_to_send_n,
    input wire serial2_spi_data_out,
    // pad side, order {port_b_bit4, port_b_bit3, port_a_bit0, port_a_bit7}
    input wire [3:0] pad_in,
    output reg [3:0] pad_out,
    output reg [3:0] pad_oe,
    output reg usb_minus_pad_en,
    // synchronised pad levels toward logic
    output reg [3:0] gpio_in,
    output reg timer1_channel4_in,
    output reg timer2_channel1_in,
    output reg timer2_channel3_in,
    output reg timer2_channel4_in,
    output reg serial1_clear_to_send_n,
    output reg serial1_spi_clock_in,
    output reg serial1_slave_select_n,
    output reg serial2_spi_data_in
);

    localparam P_A7 = 0;
    localparam P_A0 = 1;
    localparam P_B3 = 2;
    localparam P_B4 = 3;

    // true when the mode field selects an alternate output function
    function is_alt;
        input [3:0] cfg;
        begin
            is_alt = (cfg == `PFS_CFG_ALT) || (cfg == `PFS_CFG_ALT_OD);
        end
    endfunction

    // true when the mode field selects open-drain
    function is_od;
        input [3:0] cfg;
        begin
            is_od = (cfg == `PFS_CFG_OUT_OD) || (cfg == `PFS_CFG_ALT_OD);
        end
    endfunction

    // true when the mode field selects a plain push-pull or open-drain output
    function is_gpio_out;
        input [3:0] cfg;
        begin
            is_gpio_out = (cfg == `PFS_CFG_OUT) || (cfg == `PFS_CFG_OUT_OD);
        end
    endfunction

    wire [3:0] cfg_a7 = porta_high_config[`PFS_PA7_CFG_HI:`PFS_PA7_CFG_LO];
    wire [3:0] cfg_a0 = porta_low_config[`PFS_PA0_CFG_HI:`PFS_PA0_CFG_LO];
    wire [3:0] cfg_b3 = portb_low_config[`PFS_PB3_CFG_HI:`PFS_PB3_CFG_LO];
    wire [3:0] cfg_b4 = portb_high_config[`PFS_PB4_CFG_HI:`PFS_PB4_CFG_LO];

    wire regen_dis = debug_pin_config[`PFS_DBG_REGEN_DIS_BIT];
    wire remap_c1 = timer2_remap_option[`PFS_T2_REMAP_C1_BIT];
    wire remap_c3 = timer2_remap_option[`PFS_T2_REMAP_C3_BIT];
    wire remap_c4 = timer2_remap_option[`PFS_T2_REMAP_C4_BIT];
    wire t1c4_en = timer1_channel_enable[`PFS_CCER_C4_BIT];
    wire t2c1_en = timer2_channel_enable[`PFS_CCER_C1_BIT];
    wire t2c3_en = timer2_channel_enable[`PFS_CCER_C3_BIT];
    wire t2c4_en = timer2_channel_enable[`PFS_CCER_C4_BIT];

    // serial mode and role decode
    wire sc1_uart = (serial1_mode_select == `PFS_MODE_UART);
    wire sc1_spi = (serial1_mode_select == `PFS_MODE_SPI);
    wire sc2_spi = (serial2_mode_select == `PFS_MODE_SPI);
    wire sc1_slave = serial1_spi_config[`PFS_SPI_SLAVE_BIT];
    wire sc2_slave = serial2_spi_config[`PFS_SPI_SLAVE_BIT];
    wire sc1_hs = sc1_uart && serial1_uart_config[`PFS_UART_HS_EN_BIT];

    // timer2 channels own their pad only when routed here and enabled
    wire t2c1_here = !remap_c1;
    wire t2c3_here = remap_c3;
    wire t2c4_here = remap_c4;
    wire t2c1_drive = t2c1_here && t2c1_en;
    wire t2c3_drive = t2c3_here && t2c3_en;
    wire t2c4_drive = t2c4_here && t2c4_en;

    // analog usb function on the bit0 pad
    wire usb_sel = (HAS_USB != 0) && (cfg_a0 == `PFS_CFG_ANALOG);

    // synchronised pad inputs
    reg [3:0] pad_s1_r;
    reg [3:0] pad_s2_r;

    // next values of pad drivers, one pair per pad
    reg a7_out_nxt;
    reg a7_oe_nxt;
    reg a0_out_nxt;
    reg a0_oe_nxt;
    reg b3_out_nxt;
    reg b3_oe_nxt;
    reg b4_out_nxt;
    reg b4_oe_nxt;

    // alternate function value per pad, and claim for the bit0, bit3 and bit4 pads
    reg a7_alt_v;
    reg a0_alt_on;
    reg a0_alt_v;
    reg b3_alt_on;
    reg b3_alt_v;
    reg b4_alt_on;
    reg b4_alt_v;

    // bit7 pad: regulator enable has priority until disabled
    always @* begin
        a7_out_nxt = 1'b0;
        a7_oe_nxt = 1'b0;
        a7_alt_v = t1c4_en ? timer1_channel4_out : gpio_out[P_A7];
        if (!regen_dis) begin
            a7_oe_nxt = !reg_enable_n; // open-drain pull low
        end else if (is_alt(cfg_a7)) begin
            a7_out_nxt = a7_alt_v;
            a7_oe_nxt = is_od(cfg_a7) ? !a7_alt_v : 1'b1;
        end else if (is_gpio_out(cfg_a7)) begin
            a7_out_nxt = gpio_out[P_A7];
            a7_oe_nxt = is_od(cfg_a7) ? !gpio_out[P_A7] : 1'b1;
        end
    end

    // bit0 pad: timer2 ch1 wins over serial2 data out
    always @* begin
        a0_out_nxt = 1'b0;
        a0_oe_nxt = 1'b0;
        a0_alt_on = 1'b0;
        a0_alt_v = 1'b0;
        if (t2c1_drive) begin
            a0_alt_on = 1'b1;
            a0_alt_v = timer2_channel1_out;
        end else if (sc2_spi && !sc2_slave) begin
            a0_alt_on = 1'b1;
            a0_alt_v = serial2_spi_data_out;
        end
        if (usb_sel) begin
            a0_oe_nxt = 1'b0;
        end else if (is_alt(cfg_a0)) begin
            a0_out_nxt = a0_alt_on ? a0_alt_v : gpio_out[P_A0];
            a0_oe_nxt = a0_alt_on && !(is_od(cfg_a0) && a0_alt_v);
        end else if (is_gpio_out(cfg_a0)) begin
            a0_out_nxt = gpio_out[P_A0];
            a0_oe_nxt = is_od(cfg_a0) ? !gpio_out[P_A0] : 1'b1;
        end
    end

    // bit3 pad: timer2 ch3 wins over serial1 master clock
    always @* begin
        b3_out_nxt = 1'b0;
        b3_oe_nxt = 1'b0;
        b3_alt_on = 1'b0;
        b3_alt_v = 1'b0;
        if (t2c3_drive) begin
            b3_alt_on = 1'b1;
            b3_alt_v = timer2_channel3_out;
        end else if (sc1_spi && !sc1_slave) begin
            b3_alt_on = 1'b1;
            b3_alt_v = serial1_spi_clock_out;
        end
        if (is_alt(cfg_b3)) begin
            b3_out_nxt = b3_alt_on ? b3_alt_v : gpio_out[P_B3];
            b3_oe_nxt = b3_alt_on && !(is_od(cfg_b3) && b3_alt_v);
        end else if (is_gpio_out(cfg_b3)) begin
            b3_out_nxt = gpio_out[P_B3];
            b3_oe_nxt = is_od(cfg_b3) ? !gpio_out[P_B3] : 1'b1;
        end
    end

    // bit4 pad: timer2 ch4 wins over serial1 request to send
    always @* begin
        b4_out_nxt = 1'b0;
        b4_oe_nxt = 1'b0;
        b4_alt_on = 1'b0;
        b4_alt_v = 1'b0;
        if (t2c4_drive) begin
            b4_alt_on = 1'b1;
            b4_alt_v = timer2_channel4_out;
        end else if (sc1_hs) begin
            b4_alt_on = 1'b1;
            b4_alt_v = serial1_request_to_send_n;
        end
        if (is_alt(cfg_b4)) begin
            b4_out_nxt = b4_alt_on ? b4_alt_v : gpio_out[P_B4];
            b4_oe_nxt = b4_alt_on && !(is_od(cfg_b4) && b4_alt_v);
        end else if (is_gpio_out(cfg_b4)) begin
            b4_out_nxt = gpio_out[P_B4];
            b4_oe_nxt = is_od(cfg_b4) ? !gpio_out[P_B4] : 1'b1;
        end
    end

    // two-stage input synchroniser
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_s1_r <= 4'h0;
            pad_s2_r <= 4'h0;
        end else begin
            pad_s1_r <= pad_in;
            pad_s2_r <= pad_s1_r;
        end
    end

    // registered pad drivers
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pad_out <= 4'h0;
            pad_oe <= 4'h1; // regulator enable asserted from reset
            usb_minus_pad_en <= 1'b0;
        end else begin
            pad_out <= {b4_out_nxt, b3_out_nxt, a0_out_nxt, a7_out_nxt};
            pad_oe <= {b4_oe_nxt, b3_oe_nxt, a0_oe_nxt, a7_oe_nxt};
            usb_minus_pad_en <= usb_sel;
        end
    end

    // plain port and timer inputs from the synchronised pads
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_in <= 4'h0;
            timer1_channel4_in <= 1'b0;
            timer2_channel1_in <= 1'b0;
            timer2_channel3_in <= 1'b0;
            timer2_channel4_in <= 1'b0;
        end else begin
            gpio_in <= pad_s2_r;
            timer1_channel4_in <= pad_s2_r[P_A7];
            timer2_channel1_in <= t2c1_here & pad_s2_r[P_A0];
            timer2_channel3_in <= t2c3_here & pad_s2_r[P_B3];
            timer2_channel4_in <= t2c4_here & pad_s2_r[P_B4];
        end
    end

    // serial inputs, held idle when not routed
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            serial1_clear_to_send_n <= 1'b0;
            serial1_spi_clock_in <= 1'b0;
            serial1_slave_select_n <= 1'b1;
            serial2_spi_data_in <= 1'b0;
        end else begin
            // inactive handshake reads low (clear to send) when unused
            serial1_clear_to_send_n <= sc1_hs & pad_s2_r[P_B3];
            serial1_spi_clock_in <= sc1_spi & sc1_slave & pad_s2_r[P_B3];
            serial1_slave_select_n <= !(sc1_spi && sc1_slave) | pad_s2_r[P_B4];
            serial2_spi_data_in <= sc2_spi & sc2_slave & pad_s2_r[P_A0];
        end
    end

endmodule
`default_nettype wire

// [tb/pfs_chk_sva.sv]
// assertions on pad drive and routed peripheral inputs
`timescale 1ns/1ns
`default_nettype none
`include "pfs_defs.vh"
module pfs_chk (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [15:0] porta_high_config,
    input wire logic [15:0] porta_low_config,
    input wire logic [15:0] portb_low_config,
    input wire logic [7:0] debug_pin_config,
    input wire logic [7:0] timer2_remap_option,
    input wire logic [15:0] timer1_channel_enable,
    input wire logic [15:0] timer2_channel_enable,
    input wire logic [7:0] serial1_spi_config,
    input wire logic [1:0] serial1_mode_select,
    input wire logic reg_enable_n,
    input wire logic timer1_channel4_out,
    input wire logic timer2_channel3_out,
    input wire logic [3:0] pad_in,
    input wire logic [3:0] pad_out,
    input wire logic [3:0] pad_oe,
    input wire logic usb_minus_pad_en,
    input wire logic timer1_channel4_in,
    input wire logic serial1_slave_select_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // decoded selections
    wire a7_t1 = debug_pin_config[4] && porta_high_config[15:12] == `PFS_CFG_ALT;
    wire b3_alt = portb_low_config[15:12] == `PFS_CFG_ALT;
    wire s1_spi = serial1_mode_select == `PFS_MODE_SPI;
    wire s1_slv = s1_spi && serial1_spi_config[4];
    // pad level held across the sync depth
    sequence s_a7_steady;
        $stable(pad_in[0]) [*4];
    endsequence
    sequence s_ssel_steady;
        ($stable(pad_in[3]) && s1_slv) [*4];
    endsequence
    a_regen_drive: assert property (!debug_pin_config[4] |=>
        pad_oe[0] == !$past(reg_enable_n) && !(pad_oe[0] && pad_out[0]))
        else $error("regulator enable drive wrong");
    a_t1_route: assert property (a7_t1 && timer1_channel_enable[12] |=>
        pad_oe[0] && pad_out[0] == $past(timer1_channel4_out))
        else $error("timer1 output not on pad");
    a_t1_input: assert property (s_a7_steady |-> timer1_channel4_in == pad_in[0])
        else $error("timer1 input not following pad");
    a_t2c3_route: assert property (b3_alt && timer2_remap_option[6] &&
        timer2_channel_enable[8] |=> pad_oe[2] && pad_out[2] == $past(timer2_channel3_out))
        else $error("timer2 ch3 not on pad");
    a_b3_idle: assert property (b3_alt && !(timer2_remap_option[6] &&
        timer2_channel_enable[8]) && serial1_mode_select == `PFS_MODE_OFF |=> !pad_oe[2])
        else $error("bit3 pad driven with no function");
    a_usb_analog: assert property (porta_low_config[3:0] == 4'h0 |=> usb_minus_pad_en)
        else $error("usb pad not enabled");
    a_ssel_follow: assert property (s_ssel_steady |-> serial1_slave_select_n == pad_in[3])
        else $error("slave select not following pad");
    a_ssel_idle: assert property ((!s1_spi) [*4] |-> serial1_slave_select_n)
        else $error("slave select active outside spi");
endmodule
bind pfs_pad_function_select pfs_chk pfs_chk_i (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .porta_high_config(porta_high_config),
    .porta_low_config(porta_low_config),
    .portb_low_config(portb_low_config),
    .debug_pin_config(debug_pin_config),
    .timer2_remap_option(timer2_remap_option),
    .timer1_channel_enable(timer1_channel_enable),
    .timer2_channel_enable(timer2_channel_enable),
    .serial1_spi_config(serial1_spi_config),
    .serial1_mode_select(serial1_mode_select),
    .reg_enable_n(reg_enable_n),
    .timer1_channel4_out(timer1_channel4_out),
    .timer2_channel3_out(timer2_channel3_out),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .usb_minus_pad_en(usb_minus_pad_en),
    .timer1_channel4_in(timer1_channel4_in),
    .serial1_slave_select_n(serial1_slave_select_n)
);
`default_nettype wire

// [tb/pfs_pad_model.sv]
// far-side pad model: chip drive or board level
`timescale 1ns/1ns
`default_nettype none
module pfs_pad_model (
    input wire logic [3:0] pad_out,
    input wire logic [3:0] pad_oe,
    input wire logic [3:0] ext,
    output logic [3:0] pad_in
);
    // chip drive wins, otherwise the board level
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule
`default_nettype wire

// [tb/testbench.sv]
// directed testbench for the pad function select block
`timescale 1ns/1ns
`default_nettype none
`include "pfs_defs.vh"
module testbench;
    logic sys_clk = 1'h0, arst_n = 1'h0, reg_enable_n = 1'h0, timer1_channel4_out = 1'h0;
    logic [15:0] porta_high_config = 16'h0, porta_low_config = 16'h0, portb_low_config = 16'h0;
    logic [15:0] portb_high_config = 16'h0, timer1_channel_enable = 16'h0;
    logic [15:0] timer2_channel_enable = 16'h0;
    logic [7:0] debug_pin_config = 8'h0, timer2_remap_option = 8'h0, serial1_uart_config = 8'h0;
    logic [7:0] serial1_spi_config = 8'h0, serial2_spi_config = 8'h0;
    logic [1:0] serial1_mode_select = 2'h0, serial2_mode_select = 2'h0;
    logic [3:0] gpio_out = 4'h0, ext = 4'h0;
    logic timer2_channel1_out = 1'h0, timer2_channel3_out = 1'h0, timer2_channel4_out = 1'h0;
    logic serial1_spi_clock_out = 1'h0, serial1_request_to_send_n = 1'h0;
    logic serial2_spi_data_out = 1'h0;
    wire [3:0] pad_in, pad_out, pad_oe, gpio_in;
    wire usb_minus_pad_en, timer1_channel4_in, timer2_channel1_in, timer2_channel3_in;
    wire timer2_channel4_in, serial1_clear_to_send_n, serial1_spi_clock_in;
    wire serial1_slave_select_n, serial2_spi_data_in;
    int errors = 0;
    int checks = 0;
    always #10 sys_clk = ~sys_clk;
    pfs_pad_function_select pfs_pad_function_select_i (
        .sys_clk(sys_clk), .arst_n(arst_n),
        .porta_high_config(porta_high_config), .porta_low_config(porta_low_config),
        .portb_low_config(portb_low_config), .portb_high_config(portb_high_config),
        .debug_pin_config(debug_pin_config), .timer2_remap_option(timer2_remap_option),
        .timer1_channel_enable(timer1_channel_enable),
        .timer2_channel_enable(timer2_channel_enable),
        .serial1_uart_config(serial1_uart_config), .serial1_spi_config(serial1_spi_config),
        .serial1_mode_select(serial1_mode_select), .serial2_spi_config(serial2_spi_config),
        .serial2_mode_select(serial2_mode_select), .gpio_out(gpio_out),
        .reg_enable_n(reg_enable_n), .timer1_channel4_out(timer1_channel4_out),
        .timer2_channel1_out(timer2_channel1_out), .timer2_channel3_out(timer2_channel3_out),
        .timer2_channel4_out(timer2_channel4_out),
        .serial1_spi_clock_out(serial1_spi_clock_out),
        .serial1_request_to_send_n(serial1_request_to_send_n),
        .serial2_spi_data_out(serial2_spi_data_out), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .usb_minus_pad_en(usb_minus_pad_en),
        .gpio_in(gpio_in), .timer1_channel4_in(timer1_channel4_in),
        .timer2_channel1_in(timer2_channel1_in), .timer2_channel3_in(timer2_channel3_in),
        .timer2_channel4_in(timer2_channel4_in),
        .serial1_clear_to_send_n(serial1_clear_to_send_n),
        .serial1_spi_clock_in(serial1_spi_clock_in),
        .serial1_slave_select_n(serial1_slave_select_n),
        .serial2_spi_data_in(serial2_spi_data_in)
    );
    pfs_pad_model pfs_pad_model_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext(ext), .pad_in(pad_in));
    // compare one packed result
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // directed sequence, inputs change at the falling edge
    initial begin
        step(8);
        chk(8'h10, {pad_oe, pad_out});
        arst_n = 1'h1;
        reg_enable_n = 1'h1;
        step(2);
        chk(8'h0, {7'h0, pad_oe[0]});
        {reg_enable_n, debug_pin_config, porta_high_config} = {1'h0, 8'h10, 16'h9000};
        {timer1_channel_enable, timer1_channel4_out} = {16'h1000, 1'h1};
        step(5);
        chk(8'h7, {5'h0, pad_oe[0], pad_out[0], timer1_channel4_in});
        timer1_channel_enable = 16'h0;
        step(2);
        chk(8'h0, {7'h0, pad_out[0]});
        {porta_high_config, ext} = {16'h4000, 4'hd};
        step(5);
        chk(8'h3, {6'h0, timer1_channel4_in, gpio_in[0]});
        $display("pa7 routing done");
        {portb_low_config, portb_high_config} = {16'h9000, 16'h0009};
        {timer2_channel3_out, timer2_channel4_out} = 2'h3;
        for (int i = 0; i < 3; i++) begin
            timer2_remap_option = (i != 0) ? 8'hc0 : 8'h00;
            timer2_channel_enable = (i != 2) ? 16'h1100 : 16'h0;
            step(5);
            chk({4'h0, {4{i == 1}}}, {4'h0, pad_oe[3:2], pad_out[3:2] & pad_oe[3:2]});
            chk({6'h0, {2{i != 0}}}, {6'h0, timer2_channel4_in, timer2_channel3_in});
        end
        $display("timer2 routing done");
        {timer2_remap_option, timer2_channel_enable} = {8'h0, 16'h1};
        {porta_low_config, timer2_channel1_out} = {16'h9, 1'h1};
        step(2);
        chk(8'h3, {6'h0, pad_oe[1], pad_out[1]});
        step(3);
        chk(8'h1, {7'h0, timer2_channel1_in});
        {timer2_remap_option, serial2_mode_select} = {8'h10, `PFS_MODE_SPI};
        for (int i = 0; i < 2; i++) begin
            serial2_spi_data_out = i[0];
            step(2);
            chk({6'h0, 1'h1, i[0]}, {6'h0, pad_oe[1], pad_out[1]});
        end
        {serial2_spi_config, ext} = {8'h10, 4'h6};
        step(5);
        chk(8'h1, {6'h0, pad_oe[1], serial2_spi_data_in});
        {serial2_mode_select, porta_low_config} = {`PFS_MODE_OFF, 16'h0};
        step(5);
        chk(8'h1, {5'h0, timer2_channel1_in, serial2_spi_data_in, usb_minus_pad_en});
        $display("pa0 routing done");
        {serial1_mode_select, serial1_uart_config} = {`PFS_MODE_UART, 8'h20};
        {portb_low_config, timer2_remap_option} = {16'h4000, 8'h0};
        step(5);
        chk(8'h21, {2'h0, pad_oe[3], pad_out[3], 3'h0, serial1_clear_to_send_n});
        serial1_uart_config = 8'h0;
        step(5);
        chk(8'h0, {2'h0, pad_oe[3], pad_out[3], 3'h0, serial1_clear_to_send_n});
        {serial1_mode_select, portb_low_config} = {`PFS_MODE_SPI, 16'h9000};
        serial1_spi_clock_out = 1'h1;
        step(2);
        chk(8'h3, {6'h0, pad_oe[2], pad_out[2]});
        serial1_spi_config = 8'h10;
        step(5);
        chk(8'h2, {5'h0, pad_oe[2], serial1_spi_clock_in, serial1_slave_select_n});
        $display("serial routing done");
        results();
    end
endmodule
`default_nettype wire
